// [design/adcct_map.vh]
`ifndef ADCCT_MAP_VH
`define ADCCT_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define ADCCT_OFS_CTRL      4'h0
`define ADCCT_OFS_STAT      4'h4
`define ADCCT_OFS_RESULT    4'h8

// ****************************************
// field positions
// ****************************************
`define ADCCT_BCS_HI        15
`define ADCCT_BCS_LO        14
`define ADCCT_STS_HI        13
`define ADCCT_STS_LO        12
`define ADCCT_START_BIT     0
`define ADCCT_BUSY_BIT      0
`define ADCCT_DONE_BIT      1

// ****************************************
// reset and start values
// ****************************************
`define ADCCT_CTRL_RST      16'h0000
`define ADCCT_RESULT_RST    10'h000
`define ADCCT_TRIAL_INIT    10'h200

// ****************************************
// timing counts
// ****************************************
`define ADCCT_DIV_00        5'h04
`define ADCCT_DIV_01        5'h02
`define ADCCT_DIV_10        5'h10
`define ADCCT_DIV_11        5'h08
`define ADCCT_SAMPLE_BASE   7'h08
`define ADCCT_CONV_PERIODS  6'h28
`define ADCCT_STEP_PERIODS  2'h3

`endif

// [design/adcct_sync.v]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// three-stage pin synchroniser
// ****************************************
module adcct_sync (
    // clock and reset
    input  wire mclk,
    input  wire srst,
    // pin and synchronised level
    input  wire pin_in,
    output reg  level_q
);

    reg stage1_q;
    reg stage2_q;
    reg stage3_q;

    always @(posedge mclk) begin
        if (srst) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
            level_q  <= 1'b0;
        end else begin
            stage1_q <= pin_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            if (stage2_q == stage3_q) begin
                level_q <= stage3_q;
            end
        end
    end

endmodule // adcct_sync

`default_nettype wire

// [design/adcct_clkdiv.v]
`timescale 1ns/1ps
`default_nettype none
`include "adcct_map.vh"

// ****************************************
// basic clock tick from cpu clock
// ****************************************
module adcct_clkdiv (
    // clock and reset
    input  wire       mclk,
    input  wire       srst,
    // control
    input  wire       clear,
    input  wire [1:0] basic_clock_select,
    // one pulse per basic clock period
    output wire       tick
);

    reg  [4:0] cnt_q;
    reg  [4:0] div;

    always @* begin
        case (basic_clock_select)
            2'b00:   div = `ADCCT_DIV_00;
            2'b01:   div = `ADCCT_DIV_01;
            2'b10:   div = `ADCCT_DIV_10;
            default: div = `ADCCT_DIV_11;
        endcase
    end

    assign tick = ~clear & (cnt_q == div - 5'h01);

    always @(posedge mclk) begin
        if (srst || clear || tick) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

endmodule // adcct_clkdiv

`default_nettype wire

// [design/adcct_top.v]
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "adcct_map.vh"

module adcct_top (
    // clock and reset
    input  wire        mclk,
    input  wire        srst,
    // avalon-mm slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // analog front end
    input  wire        comp_in,
    output reg         sample_en_q,
    output reg  [9:0]  dac_code_q,
    // conversion status
    output wire        conv_done,
    output wire        conv_busy
);

    // ****************************************
    // states
    // ****************************************
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_SAMPLE = 3'h1;
    localparam [2:0] ST_CONV   = 3'h2;
    localparam [2:0] ST_LOAD1  = 3'h3;
    localparam [2:0] ST_LOAD2  = 3'h4;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [15:0] ctrl_q;
    reg  [15:0] ctrl_d;
    reg  [1:0]  run_bcs_q;
    reg  [1:0]  run_sts_q;
    reg  [6:0]  period_q;
    reg  [9:0]  sar_q;
    wire [9:0]  sar_d;
    reg  [9:0]  result_q;
    reg         done_q;
    reg         done_d;
    reg         ack_q;
    wire        ack_d;
    reg  [31:0] readdata_d;
    wire        tick;
    wire        comp_s;
    wire        req;
    wire        wr_take;
    wire        start;
    wire        clr_done;
    wire        div_clear;
    wire [6:0]  sample_n;
    wire [9:0]  bit_sel;
    wire        in_sample;
    wire        in_conv;
    wire        sample_last;
    wire        step_end;
    wire        conv_last;
    genvar      gi;

    // ****************************************
    // avalon handshake
    // ****************************************
    assign req         = read | write;
    assign waitrequest = req & ~ack_q;
    assign wr_take     = write & ack_q;
    assign start       = wr_take & (address == `ADCCT_OFS_CTRL)
                         & writedata[`ADCCT_START_BIT] & (state_q == ST_IDLE);
    assign clr_done    = wr_take & (address == `ADCCT_OFS_STAT)
                         & writedata[`ADCCT_DONE_BIT];
    assign ack_d       = req & ~ack_q;

    always @(posedge mclk) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    always @* begin
        case (address)
            `ADCCT_OFS_CTRL:   readdata_d = {16'h0000, ctrl_q};
            `ADCCT_OFS_STAT:   readdata_d = {30'h0000000, done_q, conv_busy};
            `ADCCT_OFS_RESULT: readdata_d = {22'h00000, result_q};
            default:           readdata_d = 32'h00000000;
        endcase
    end

    always @(posedge mclk) begin
        if (srst) begin
            readdata <= 32'h00000000;
        end else if (read & ~ack_q) begin
            readdata <= readdata_d;
        end
    end

    // ****************************************
    // control word
    // ****************************************
    always @* begin
        ctrl_d = ctrl_q;
        if (wr_take && address == `ADCCT_OFS_CTRL) begin
            // start bit reads back as zero
            ctrl_d = {writedata[15:1], 1'b0};
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            ctrl_q <= `ADCCT_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ****************************************
    // basic clock and comparator
    // ****************************************
    assign div_clear = (state_q == ST_IDLE);

    adcct_clkdiv u_clkdiv (
        .mclk               (mclk),
        .srst               (srst),
        .clear              (div_clear),
        .basic_clock_select (run_bcs_q),
        .tick               (tick)
    );

    adcct_sync u_sync (
        .mclk    (mclk),
        .srst    (srst),
        .pin_in  (comp_in),
        .level_q (comp_s)
    );

    // ****************************************
    // sequencer
    // ****************************************
    assign sample_n    = `ADCCT_SAMPLE_BASE << run_sts_q;
    assign bit_sel     = `ADCCT_TRIAL_INIT >> period_q[5:2];
    assign in_sample   = (state_q == ST_SAMPLE);
    assign in_conv     = (state_q == ST_CONV);
    assign sample_last = in_sample & tick & (period_q == sample_n - 7'h01);
    assign step_end    = in_conv & tick & (period_q[1:0] == `ADCCT_STEP_PERIODS);
    assign conv_last   = step_end
                         & (period_q == {1'b0, `ADCCT_CONV_PERIODS} - 7'h01);
    assign conv_busy   = (state_q != ST_IDLE);
    assign conv_done   = (state_q == ST_LOAD2);

    // ****************************************
    // state machine
    // ****************************************
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (sample_last) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_last) begin
                    state_d = ST_LOAD1;
                end
            end
            ST_LOAD1: begin
                state_d = ST_LOAD2;
            end
            ST_LOAD2: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (srst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // selects latched at start
    // ****************************************
    always @(posedge mclk) begin
        if (srst) begin
            run_bcs_q <= 2'h0;
            run_sts_q <= 2'h0;
        end else if (start) begin
            run_bcs_q <= writedata[`ADCCT_BCS_HI:`ADCCT_BCS_LO];
            run_sts_q <= writedata[`ADCCT_STS_HI:`ADCCT_STS_LO];
        end
    end

    // ****************************************
    // basic period counter
    // ****************************************
    always @(posedge mclk) begin
        if (srst || div_clear || sample_last) begin
            period_q <= 7'h00;
        end else if (tick) begin
            period_q <= period_q + 7'h01;
        end
    end

    // ****************************************
    // sample window
    // ****************************************
    always @(posedge mclk) begin
        if (srst) begin
            sample_en_q <= 1'b0;
        end else if (start) begin
            sample_en_q <= 1'b1;
        end else if (sample_last) begin
            sample_en_q <= 1'b0;
        end
    end

    // ****************************************
    // successive approximation bits
    // ****************************************
    generate
        for (gi = 0; gi < 10; gi = gi + 1) begin : g_sar
            // keep trial bit when input above trial level
            assign sar_d[gi] = (step_end & bit_sel[gi]) ? comp_s : sar_q[gi];
        end
    endgenerate

    always @(posedge mclk) begin
        if (srst || start) begin
            sar_q <= 10'h000;
        end else begin
            sar_q <= sar_d;
        end
    end

    // ****************************************
    // trial code
    // ****************************************
    always @(posedge mclk) begin
        if (srst) begin
            dac_code_q <= 10'h000;
        end else if (start) begin
            dac_code_q <= `ADCCT_TRIAL_INIT;
        end else if (step_end && !conv_last) begin
            dac_code_q <= sar_d | (bit_sel >> 1);
        end
    end

    // ****************************************
    // result register
    // ****************************************
    always @(posedge mclk) begin
        if (srst) begin
            result_q <= `ADCCT_RESULT_RST;
        end else if (conv_done) begin
            result_q <= sar_q;
        end
    end

    // ****************************************
    // sticky done flag, set beats clear
    // ****************************************
    always @* begin
        done_d = done_q;
        if (conv_done) begin
            done_d = 1'b1;
        end else if (clr_done) begin
            done_d = 1'b0;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

endmodule // adcct_top

`default_nettype wire

// [testbench/adcct_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// conversion timing checker
// ****
module adcct_checker (
    // clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // avalon-mm slave
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // analog front end and status
    input wire logic        comp_in,
    input wire logic        sample_en_q,
    input wire logic [9:0]  dac_code_q,
    input wire logic        conv_done,
    input wire logic        conv_busy
);
    logic [3:0]  sel_q;
    logic [11:0] cnt_q;
    logic [11:0] scnt_q;
    logic [11:0] sd;
    logic [11:0] tot;
    logic [4:0]  div;
    always_ff @(posedge mclk) begin
        if (srst)
            sel_q <= 4'h0;
        else if (write && !waitrequest && address == 4'h0 && writedata[0] && !conv_busy)
            sel_q <= writedata[15:12];
        cnt_q  <= (conv_busy && !srst) ? cnt_q + 12'h001 : 12'h000;
        scnt_q <= (sample_en_q && !srst) ? scnt_q + 12'h001 : 12'h000;
    end
    always_comb begin
        case (sel_q[3:2])
            2'h0: div = 5'h04;
            2'h1: div = 5'h02;
            2'h2: div = 5'h10;
            default: div = 5'h08;
        endcase
        sd  = (12'h008 << sel_q[1:0]) * div;
        tot = sd + 12'h028 * div + 12'h002;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_load;
        conv_done ##1 !conv_busy;
    endsequence
    property p_total; conv_done |-> cnt_q == tot - 12'h001; endproperty
    property p_sample; $fell(sample_en_q) |-> scnt_q == sd; endproperty
    property p_first; $rose(conv_busy) |-> sample_en_q; endproperty
    property p_load; conv_done |-> conv_busy ##0 s_load; endproperty
    property p_hold; sample_en_q |-> conv_busy; endproperty
    property p_quiet; conv_busy && !sample_en_q |=> !sample_en_q; endproperty
    a_total: assert property (p_total) else $error("conversion length wrong");
    a_sample: assert property (p_sample) else $error("sample length wrong");
    a_first: assert property (p_first) else $error("no sample at start");
    a_load: assert property (p_load) else $error("done not with load");
    a_hold: assert property (p_hold) else $error("sample while idle");
    a_quiet: assert property (p_quiet) else $error("resampled in conversion");
endmodule // adcct_checker
bind adcct_top adcct_checker adcct_checker_inst (.mclk(mclk), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .comp_in(comp_in), .sample_en_q(sample_en_q),
    .dac_code_q(dac_code_q), .conv_done(conv_done), .conv_busy(conv_busy));
`default_nettype wire

// [testbench/adcct_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module adcct_top_tb;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic        comp_in = 1'b0;
    logic [3:0]  address = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        sample_en_q;
    logic        conv_done;
    logic        conv_busy;
    logic [9:0]  dac_code_q;
    int          mismatches = 0;
    int          compares = 0;
    int          cyc = 0;
    int          n;
    int          d;
    always #2.5 mclk = ~mclk;
    adcct_top adcct_top_inst (.mclk(mclk), .srst(srst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .comp_in(comp_in), .sample_en_q(sample_en_q), .dac_code_q(dac_code_q),
        .conv_done(conv_done), .conv_busy(conv_busy));
    // ****
    // tasks
    // ****
    task complete_run;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        address <= a;
        writedata <= wd;
        read <= !wr;
        write <= wr;
        @(posedge mclk);
        while (waitrequest) @(posedge mclk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 20000) begin
            mismatches++;
            complete_run();
        end
    end
    // ****
    // tests
    // ****
    initial begin
        logic [31:0] r;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd_chk("ctrl", 4'h0, 32'h0);
        rd_chk("status", 4'h4, 32'h0);
        rd_chk("result", 4'h8, 32'h0);
        bus(1'b1, 4'hC, 32'hF001, r);
        rd_chk("unmapped", 4'hC, 32'h0);
        rd_chk("ctrl", 4'h0, 32'h0);
        $display("test reset and map done");
        for (int i = 0; i < 16; i++) begin
            d = (i[3:2] == 2'h0) ? 4 : (i[3:2] == 2'h1) ? 2 : (i[3:2] == 2'h2) ? 16 : 8;
            comp_in <= !i[0];
            bus(1'b1, 4'h0, {16'h0, i[3:0], 12'h001}, r);
            n = 0;
            do begin
                @(posedge mclk);
                n++;
                if (!sample_en_q && n > 1)
                    comp_in <= i[0];
                if (n == 1)
                    chk("trial code", 32'h200, {22'h0, dac_code_q});
                if (n == (8 << i[1:0]) * d)
                    chk("sampling", 32'h3, {30'h0, sample_en_q, conv_busy});
                if (n == (8 << i[1:0]) * d + 1)
                    chk("hold", 32'h1, {30'h0, sample_en_q, conv_busy});
            end while (!conv_done && n < 2000);
            chk("conv time", (8 << i[1:0]) * d + 40 * d + 2, n);
            chk("last trial", i[0] ? 32'h3FF : 32'h1, {22'h0, dac_code_q});
            rd_chk("status", 4'h4, 32'h2);
            rd_chk("result", 4'h8, i[0] ? 32'h3FF : 32'h0);
            rd_chk("ctrl", 4'h0, {16'h0, i[3:0], 12'h000});
            bus(1'b1, 4'h4, 32'h2, r);
            rd_chk("status", 4'h4, 32'h0);
            $display("test conversion %0d done", i);
        end
        bus(1'b1, 4'h0, 32'h1001, r);
        repeat (20) @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd_chk("status", 4'h4, 32'h0);
        rd_chk("result", 4'h8, 32'h0);
        rd_chk("ctrl", 4'h0, 32'h0);
        $display("test reset during conversion done");
        complete_run();
    end
endmodule // adcct_top_tb
`default_nettype wire
